// ---- src/crosspoint_profile_switch_regs.sv ----
`timescale 1ns/1ns
module crosspoint_profile_switch_regs
  import xpt_pkg::*;
#(
  parameter int NP = NPORT,
  parameter int SW = SEL_W
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              register_reset_pin_n,
  input  wire logic              reg_control_pin,
  input  wire logic              equalizer_level_pin,
  input  wire logic              profile_toggle_pin,
  input  wire logic              bus_start,
  input  wire logic              bus_wr,
  input  wire logic [7:0]        bus_wdata,
  input  wire logic              bus_rd,
  output logic      [7:0]        bus_rdata,
  output logic      [NP*SW-1:0]  src_sel,
  output logic      [NP-1:0]     eq_sel,
  output logic                   secondary_active
);

  logic [7:0]       addr;
  logic             addr_phase;
  logic [7:0]       out_reg [NP];
  logic [7:0]       in_reg  [NP];
  logic [7:0]       sw_reg;
  logic             data_wr;
  logic             use_secondary;
  logic [NP*SW-1:0] pri_flat;
  logic [NP*SW-1:0] sec_flat;

  // Address falls in an eight-register port bank
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    in_bank = (a[7:3] == base[7:3]);
  endfunction

  // Register read decode
  function automatic logic [7:0] read_reg(input logic [7:0] a);
    read_reg = RSVD_READ;
    if (in_bank(a, OUT_BASE)) begin
      read_reg = out_reg[a[2:0]] & OUT_WMASK;
    end else if (in_bank(a, IN_BASE)) begin
      read_reg = in_reg[a[2:0]] & IN_WMASK;
    end else if (a == SWCTL_ADDR) begin
      read_reg = sw_reg & SW_WMASK;
    end
  endfunction

  // A data byte, not the address byte, was accepted this cycle
  assign data_wr = bus_wr && !bus_start && !addr_phase && register_reset_pin_n;

  // Address pointer: first byte after start loads it, data bytes advance it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr       <= 8'h00;
      addr_phase <= 1'b0;
    end else if (!register_reset_pin_n) begin
      addr       <= 8'h00;
      addr_phase <= 1'b0;
    end else if (bus_start) begin
      addr_phase <= 1'b1;
    end else if (bus_wr && addr_phase) begin
      addr       <= bus_wdata;
      addr_phase <= 1'b0;
    end else if (bus_wr || bus_rd) begin
      addr <= 8'(addr + 8'h01);
    end
  end

  // Read data, captured at the read strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd && !bus_wr && !bus_start) begin
      bus_rdata <= read_reg(addr);
    end
  end

  // Per-port output and input control registers
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_port
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          out_reg[g] <= {SW'(g), OUT_LOW_RESET};
        end else if (!register_reset_pin_n) begin
          out_reg[g] <= {SW'(g), OUT_LOW_RESET};
        end else if (data_wr && addr == OUT_BASE + 8'(g)) begin
          out_reg[g] <= bus_wdata & OUT_WMASK;
        end
      end

      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          in_reg[g] <= {EQ_RESET, SW'(g), IN_LOW_RESET};
        end else if (!register_reset_pin_n) begin
          in_reg[g] <= {EQ_RESET, SW'(g), IN_LOW_RESET};
        end else if (data_wr && addr == IN_BASE + 8'(g)) begin
          in_reg[g] <= bus_wdata & IN_WMASK;
        end
      end

      // Receive equalization: register bit or pin
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          eq_sel[g] <= EQ_RESET;
        end else if (reg_control_pin) begin
          eq_sel[g] <= in_reg[g][IN_EQ_BIT];
        end else begin
          eq_sel[g] <= equalizer_level_pin;
        end
      end

      assign pri_flat[g*SW +: SW] = out_reg[g][OUT_PRI_LSB +: SW];
      assign sec_flat[g*SW +: SW] = in_reg[g][IN_SEC_LSB +: SW];
    end
  endgenerate

  // Switch control; reserved range has no storage, so writes there vanish
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sw_reg <= SWCTL_RESET;
    end else if (!register_reset_pin_n) begin
      sw_reg <= SWCTL_RESET;
    end else if (data_wr && addr == SWCTL_ADDR) begin
      sw_reg <= bus_wdata & SW_WMASK;
    end
  end

  // Active profile decision
  always_comb begin
    if (sw_reg[SW_PIN_EN_BIT]) begin
      use_secondary = profile_toggle_pin;
    end else begin
      use_secondary = sw_reg[SW_REG_TRIG_BIT];
    end
  end

  // Output routing muxes
  route_select #(
    .NP (NP),
    .SW (SW)
  ) u_route (
    .mclk             (mclk),
    .nrst             (nrst),
    .use_secondary    (use_secondary),
    .pri_flat         (pri_flat),
    .sec_flat         (sec_flat),
    .src_sel          (src_sel),
    .secondary_active (secondary_active)
  );

  // Identity routing value for checks
  logic [NP*SW-1:0] ident;
  generate
    for (g = 0; g < NP; g++) begin : g_ident
      assign ident[g*SW +: SW] = SW'(g);
    end
  endgenerate

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // Equalization from register when pin control is off
  a_eq_from_reg: assert property (
    reg_control_pin |=> eq_sel[0] == $past(in_reg[0][IN_EQ_BIT])
  ) else $error("eq_sel does not follow register bit");

  a_eq_from_pin: assert property (
    !reg_control_pin |=> eq_sel == {NP{$past(equalizer_level_pin)}}
  ) else $error("eq_sel does not follow equalizer pin");

  a_pin_low_primary: assert property (
    sw_reg[SW_PIN_EN_BIT] && !profile_toggle_pin
      |=> src_sel == $past(pri_flat) && !secondary_active
  ) else $error("toggle low did not apply primary profile");

  a_pin_high_secondary: assert property (
    sw_reg[SW_PIN_EN_BIT] && profile_toggle_pin
      |=> src_sel == $past(sec_flat) && secondary_active
  ) else $error("toggle high did not apply secondary profile");

  a_pin_ignores_bit: assert property (
    sw_reg[SW_PIN_EN_BIT] |=> secondary_active == $past(profile_toggle_pin)
  ) else $error("register trigger bit affected pin-triggered profile");

  a_reg_trigger: assert property (
    !sw_reg[SW_PIN_EN_BIT] |=> secondary_active == $past(sw_reg[SW_REG_TRIG_BIT])
  ) else $error("register trigger bit not applied");

  a_reset_identity: assert property (
    !register_reset_pin_n |-> ##2 src_sel == ident
  ) else $error("routing not identity after register reset");

  a_addr_advance: assert property (
    data_wr |=> addr == 8'($past(addr) + 8'h01)
  ) else $error("address did not advance after data byte");

  a_rsvd_bits_zero: assert property (
    in_reg[0][3:0] == 4'h0 && out_reg[0][1:0] == 2'h0 && sw_reg[5:0] == 6'h00
  ) else $error("reserved bit holds a one");

  a_primary_default: assert property (
    !use_secondary |=> src_sel == $past(pri_flat)
  ) else $error("primary profile not applied");

  // Disabled pin trigger leaves a high toggle pin without effect
  a_pin_off_ignored: assert property (
    !sw_reg[SW_PIN_EN_BIT] && !sw_reg[SW_REG_TRIG_BIT] && profile_toggle_pin
      |=> !secondary_active
  ) else $error("toggle pin acted while pin trigger disabled");

  a_reg_bit_masked: assert property (
    sw_reg[SW_PIN_EN_BIT] && sw_reg[SW_REG_TRIG_BIT] && !profile_toggle_pin
      |=> !secondary_active
  ) else $error("register trigger bit acted while pin trigger enabled");

  // Secondary decision steers every output to its secondary field
  a_secondary_route: assert property (
    use_secondary |=> src_sel == $past(sec_flat)
  ) else $error("secondary profile not applied");

  // Reserved range has no storage behind it
  a_rsvd_no_write: assert property (
    data_wr && addr >= RSVD_FIRST && addr <= RSVD_LAST |=> $stable(sw_reg)
  ) else $error("write to reserved range changed switch control");

  // Read data stands until the next taken read
  a_rdata_hold: assert property (
    !(bus_rd && !bus_wr && !bus_start) |=> $stable(bus_rdata)
  ) else $error("read data changed without a read");

  // Reserved bits read back as zero
  a_in_read_mask: assert property (
    bus_rd && !bus_wr && !bus_start && in_bank(addr, IN_BASE) |=> bus_rdata[3:0] == 4'h0
  ) else $error("input register reserved bits read as one");

  a_out_read_mask: assert property (
    bus_rd && !bus_wr && !bus_start && in_bank(addr, OUT_BASE) |=> bus_rdata[1:0] == 2'h0
  ) else $error("output register reserved bits read as one");

  a_sw_read_mask: assert property (
    bus_rd && !bus_wr && !bus_start && addr == SWCTL_ADDR |=> bus_rdata[5:0] == 6'h00
  ) else $error("switch control reserved bits read as one");

  // Address byte after a start loads the pointer
  a_addr_load: assert property (
    bus_wr && addr_phase && !bus_start && register_reset_pin_n |=> addr == $past(bus_wdata)
  ) else $error("address byte not loaded");

  // Per-port checks of equalization source and reset defaults
  generate
    for (g = 0; g < NP; g++) begin : g_chk
      a_eq_reg_port: assert property (
        @(posedge mclk) disable iff (!nrst)
        reg_control_pin |=> eq_sel[g] == $past(in_reg[g][IN_EQ_BIT])
      ) else $error("port equalization does not follow register bit");

      a_eq_pin_port: assert property (
        @(posedge mclk) disable iff (!nrst)
        !reg_control_pin |=> eq_sel[g] == $past(equalizer_level_pin)
      ) else $error("port equalization does not follow equalizer pin");

      a_sec_default: assert property (
        @(posedge mclk) disable iff (!nrst)
        !register_reset_pin_n |=> in_reg[g][IN_SEC_LSB +: SW] == SW'(g)
      ) else $error("secondary source not own port after reset");

      a_pri_default: assert property (
        @(posedge mclk) disable iff (!nrst)
        !register_reset_pin_n |=> out_reg[g][OUT_PRI_LSB +: SW] == SW'(g)
      ) else $error("primary source not own port after reset");
    end
  endgenerate

  c_pin_switch: cover property (
    sw_reg[SW_PIN_EN_BIT] && $rose(profile_toggle_pin) ##1 secondary_active
  );
  c_reg_switch: cover property (
    !sw_reg[SW_PIN_EN_BIT] && $rose(sw_reg[SW_REG_TRIG_BIT])
  );
  c_burst_write: cover property (data_wr ##1 data_wr ##1 data_wr);
  c_read: cover property (bus_rd && addr == SWCTL_ADDR);
  c_reg_reset: cover property ($fell(register_reset_pin_n));

endmodule

// ---- pkg/xpt_pkg.sv ----
package xpt_pkg;

  // Array shape
  localparam int NPORT  = 8;
  localparam int SEL_W  = 3;
  localparam int DATA_W = 8;

  // Register addresses
  localparam logic [7:0] OUT_BASE    = 8'h00;
  localparam logic [7:0] IN_BASE     = 8'h08;
  localparam logic [7:0] SWCTL_ADDR  = 8'h10;
  localparam logic [7:0] RSVD_FIRST  = 8'h11;
  localparam logic [7:0] RSVD_LAST   = 8'h1A;

  // Field positions
  localparam int OUT_PRI_LSB     = 5;
  localparam int IN_EQ_BIT       = 7;
  localparam int IN_SEC_LSB      = 4;
  localparam int SW_PIN_EN_BIT   = 7;
  localparam int SW_REG_TRIG_BIT = 6;

  // Writable bits of each register kind; all other bits read as zero
  localparam logic [7:0] OUT_WMASK = 8'hFC;
  localparam logic [7:0] IN_WMASK  = 8'hF0;
  localparam logic [7:0] SW_WMASK  = 8'hC0;

  // Reset values (source fields default to the register's own port)
  localparam logic [7:0] SWCTL_RESET   = 8'h00;
  localparam logic [4:0] OUT_LOW_RESET = 5'h00;
  localparam logic       EQ_RESET      = 1'b0;
  localparam logic [3:0] IN_LOW_RESET  = 4'h0;

  // Value returned for reserved and unmapped addresses
  localparam logic [7:0] RSVD_READ = 8'h00;

endpackage

// ---- src/route_select.sv ----
`timescale 1ns/1ns
module route_select
  import xpt_pkg::*;
#(
  parameter int NP = NPORT,
  parameter int SW = SEL_W
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              use_secondary,
  input  wire logic [NP*SW-1:0]  pri_flat,
  input  wire logic [NP*SW-1:0]  sec_flat,
  output logic      [NP*SW-1:0]  src_sel,
  output logic                   secondary_active
);

  // One profile decision steers every output mux
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_out
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          src_sel[g*SW +: SW] <= SW'(g);
        end else if (use_secondary) begin
          src_sel[g*SW +: SW] <= sec_flat[g*SW +: SW];
        end else begin
          src_sel[g*SW +: SW] <= pri_flat[g*SW +: SW];
        end
      end
    end
  endgenerate

  // Profile flag for observation
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      secondary_active <= 1'b0;
    end else begin
      secondary_active <= use_secondary;
    end
  end

endmodule

// ---- sim/host_model.sv ----
`timescale 1ns/1ns
module host_model (
  input  wire logic       mclk,
  output logic            bus_start,
  output logic            bus_wr,
  output logic [7:0]      bus_wdata,
  output logic            bus_rd,
  input  wire logic [7:0] bus_rdata
);
  // Idle bus at time zero
  initial begin
    bus_start = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'hA5;
  end
  // One bus cycle; released data shows the inverse of its last value
  task automatic cyc(input logic s, input logic w, input logic r, input logic [7:0] d);
    @(negedge mclk);
    bus_start <= s;
    bus_wr <= w;
    bus_rd <= r;
    bus_wdata <= w ? d : ~bus_wdata;
  endtask
  // Start then register address
  task automatic start(input logic [7:0] a);
    cyc(1'b1, 1'b0, 1'b0, 8'h00);
    cyc(1'b0, 1'b1, 1'b0, a);
  endtask
  // Single byte write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start(a);
    cyc(1'b0, 1'b1, 1'b0, d);
    cyc(1'b0, 1'b0, 1'b0, 8'h00);
  endtask
  // Single byte read, taken a cycle after the request
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    start(a);
    cyc(1'b0, 1'b0, 1'b1, 8'h00);
    cyc(1'b0, 1'b0, 1'b0, 8'h00);
    q = bus_rdata;
  endtask
endmodule

// ---- sim/test_crosspoint_profile_switch_regs.sv ----
`timescale 1ns/1ns
module test_crosspoint_profile_switch_regs;
  import xpt_pkg::*;
  logic        mclk;
  logic        nrst;
  logic        reset_n;
  logic        reg_ctl;
  logic        eq_pin;
  logic        toggle;
  logic        bus_start;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  bus_wdata;
  logic [7:0]  bus_rdata;
  logic [23:0] src_sel;
  logic [7:0]  eq_sel;
  logic        sec_act;
  logic [23:0] pri_v;
  logic [23:0] sec_v;
  logic [7:0]  q;
  int          failures;
  int          checks;
  // Rows: switch control, toggle level, secondary expected
  logic [9:0]  rows [8] = '{10'h002, 10'h101, 10'h103, 10'h300, 10'h303,
                             10'h200, 10'h203, 10'h000};

  crosspoint_profile_switch_regs dut (.mclk(mclk), .nrst(nrst),
    .register_reset_pin_n(reset_n), .reg_control_pin(reg_ctl), .equalizer_level_pin(eq_pin),
    .profile_toggle_pin(toggle), .bus_start(bus_start), .bus_wr(bus_wr),
    .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .src_sel(src_sel),
    .eq_sel(eq_sel), .secondary_active(sec_act));
  host_model host (.mclk(mclk), .bus_start(bus_start), .bus_wr(bus_wr),
    .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #(50 * 2000);
    failures++;
    close_out();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    reset_n = 1'b1;
    reg_ctl = 1'b1;
    eq_pin = 1'b0;
    toggle = 1'b0;
    failures = 0;
    checks = 0;
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    chk("src", src_sel, 24'hFAC688);
    host.rd(SWCTL_ADDR, q);
    chk("swctl", {16'h0, q}, 24'h000000);
    $display("reset test done");
    for (int g = 0; g < 8; g++) begin
      pri_v[3*g +: 3] = 3'(7 - g);
      sec_v[3*g +: 3] = 3'((g + 3) % 8);
    end
    // Burst of sixteen bytes over output and input registers
    host.start(OUT_BASE);
    for (int g = 0; g < 8; g++) host.cyc(1'b0, 1'b1, 1'b0, {pri_v[3*g +: 3], 5'h00});
    for (int g = 0; g < 8; g++) host.cyc(1'b0, 1'b1, 1'b0, {g[0], sec_v[3*g +: 3], 4'h0});
    host.cyc(1'b0, 1'b0, 1'b0, 8'h00);
    host.rd(8'h09, q);
    chk("in1", {16'h0, q}, 24'h0000C0);
    chk("eq_reg", {16'h0, eq_sel}, 24'h0000AA);
    reg_ctl = 1'b0;
    eq_pin = 1'b1;
    repeat (2) @(negedge mclk);
    chk("eq_pin", {16'h0, eq_sel}, 24'h0000FF);
    reg_ctl = 1'b1;
    $display("config test done");
    foreach (rows[i]) begin
      host.wr(SWCTL_ADDR, rows[i][9:2]);
      toggle = rows[i][1];
      repeat (2) @(negedge mclk);
      chk("active", {23'h0, sec_act}, {23'h0, rows[i][0]});
      chk("route", src_sel, rows[i][0] ? sec_v : pri_v);
      $display("row %0d done", i);
    end
    host.wr(SWCTL_ADDR, 8'hFF);
    host.rd(SWCTL_ADDR, q);
    chk("mask", {16'h0, q}, 24'h0000C0);
    host.rd(RSVD_FIRST, q);
    host.wr(RSVD_FIRST, 8'h00);
    host.rd(SWCTL_ADDR, q);
    chk("rsvd_wr", {16'h0, q}, 24'h0000C0);
    $display("reserved test done");
    reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    chk("rst_src", src_sel, 24'hFAC688);
    host.rd(8'h09, q);
    chk("in1_rst", {16'h0, q}, 24'h000010);
    host.rd(8'h02, q);
    chk("out2_rst", {16'h0, q}, 24'h000040);
    $display("register reset test done");
    close_out();
  end
endmodule
